// ===== verilog/ptc_pkg.sv
// Constants, register map and field layout of the periodic timer.
`default_nettype none
package ptc_pkg;
	localparam int CNT_W = 10;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_ZERO = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_PER_LO = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_PER_HI = 4'h7;
	localparam logic [ADDR_W-1:0] ADDR_FLAGS = 4'h8;
	localparam int PAUSE_BIT = 7;
	localparam int ON_BIT = 3;
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int ACT_HI = 5;
	localparam int ACT_LO = 4;
	localparam int INIT_BIT = 3;
	localparam int INV_BIT = 2;
	localparam int CCLR_BIT = 0;
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] PWM_INACTIVE = 2'h0;
	localparam logic [1:0] PWM_ACTIVE = 2'h1;
	localparam logic [1:0] PWM_WAVE = 2'h2;
	localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
	localparam logic [CNT_W:0] PWM_FULL_PERIOD = 11'h400;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [5:0] HI_PAD = 6'h00;
endpackage : ptc_pkg
`default_nettype wire

// ===== verilog/ptc_cmp_if.sv
// Carrier between the timer core and one of its comparators.
`timescale 1ns/100ps
`default_nettype none
interface ptc_cmp_if;
	import ptc_pkg::*;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] compare_value;
	logic step;
	logic hit;
	logic value_zero;
	modport timer (output count_next, output compare_value, output step,
		input hit, input value_zero);
	modport cmp (input count_next, input compare_value, input step,
		output hit, output value_zero);
endinterface : ptc_cmp_if
`default_nettype wire

// ===== verilog/ptc_comparator.sv
// One 10-bit equality comparator of the periodic timer.
`timescale 1ns/100ps
`default_nettype none
module ptc_comparator
	import ptc_pkg::*;
(
	ptc_cmp_if.cmp port
);
	// The comparison looks at the value the counter is about to take, so a
	// clear lands on the same tick as the match.
	assign port.hit = port.step && (port.count_next == port.compare_value); // R24
	assign port.value_zero = (port.compare_value == CNT_ZERO);
endmodule : ptc_comparator
`default_nettype wire

// ===== verilog/ptc_timer.sv
// Periodic timer with compare match, timer and edge-aligned PWM modes.
//
// How it works
// R1: Ten-bit up-counter, readable as low byte and two-bit high byte, not writable.
// R2: Upper six bits of every high-byte register read back as zero.
// R3: Ten-bit compare-A value, read and write, zero after reset.
// R4: Ten-bit period value, read and write, zero after reset.
// R5: Mode 00 is compare match output; counter clears by overflow, A or P.
// R6: Clear select low: P match clears, zero period overflows; both flags raised.
// R7: Clear select high: A match clears, only the A flag is raised.
// R8: Compare-A zero in compare mode: overflow at 3FF, no A flag.
// R9: In compare mode only an A match moves the pin, never a P match.
// R10: On A match the pin goes high, low or toggles; code zero leaves it.
// R11: Rising counter-on bit resets the pin to the chosen initial level.
// R12: Mode 11 works as compare mode but does not drive the pin.
// R13: Mode 10 makes PWM on the pin; clear select is ignored there.
// R14: In PWM the P match clears the counter; compare-A sets the duty.
// R15: Period value 1 to 1023 gives that many timer ticks; zero gives 1024.
// R16: In PWM each A match and each P match raise their flags.
// R17: Duty at or above the period holds the output active: full duty.
// R18: In PWM action codes 00 and 01 force inactive or active; counting continues.
// R19: In PWM initial level picks polarity; invert bit inverts the pin again.
// R20: Rising counter-on bit zeroes the counter; falling stops it, keeping the count.
// R21: Compare action codes: 00 none, 01 low, 10 high, 11 toggle.
// R22: Pause bit freezes the counter; clearing it resumes from the held value.
// R23: Counter steps by one per timer tick while on and not paused.
// R24: Match when counter equals compare value; flag stays until software clears.
`timescale 1ns/100ps
`default_nettype none
module ptc_timer
	import ptc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic count_tick,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic pin_out,
	output logic pin_oe,
	output logic a_match_flag,
	output logic p_match_flag
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] cmpa_ff;
	logic [CNT_W-1:0] per_ff;
	logic on_ff;
	logic pause_ff;
	logic [1:0] mode_ff;
	logic [1:0] action_ff;
	logic init_ff;
	logic inv_ff;
	logic cclr_ff;
	logic flag_a_ff;
	logic flag_p_ff;
	logic level_ff;
	logic nxt_level;
	logic pin_out_ff;
	logic nxt_pin_out;
	logic pin_oe_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic step;
	logic on_rise;
	logic [CNT_W-1:0] cnt_plus;
	logic cmp_like;
	logic set_a;
	logic set_p;
	logic clear_cnt;
	logic clr_a;
	logic clr_p;
	logic [CNT_W:0] pwm_period;
	logic pwm_on;
	logic pwm_wave;

	ptc_cmp_if cmp_a_if ();
	ptc_cmp_if cmp_p_if ();

	assign step = on_ff && !pause_ff && count_tick; // R23 R22
	assign cnt_plus = cnt_ff + CNT_ONE; // R23
	assign on_rise = reg_wr && (reg_addr == ADDR_CTRL_ZERO) &&
		reg_wdata[ON_BIT] && !on_ff; // R11 R20
	assign cmp_like = (mode_ff == MODE_CMP) || (mode_ff == MODE_TMR); // R5 R12

	assign cmp_a_if.count_next = cnt_plus;
	assign cmp_a_if.compare_value = cmpa_ff;
	assign cmp_a_if.step = step;
	assign cmp_p_if.count_next = cnt_plus;
	assign cmp_p_if.compare_value = per_ff;
	assign cmp_p_if.step = step;

	ptc_comparator u_cmp_a (
		.port(cmp_a_if)
	);

	ptc_comparator u_cmp_p (
		.port(cmp_p_if)
	);

	// A zero compare-A would hit on the overflow wrap, which is not a match.
	always_comb begin
		set_a = 1'b0;
		set_p = 1'b0;
		clear_cnt = 1'b0;
		if (cmp_like) begin
			set_a = cmp_a_if.hit && !cmp_a_if.value_zero; // R8
			if (cclr_ff) begin
				clear_cnt = set_a; // R7
			end else begin
				set_p = cmp_p_if.hit; // R6
				clear_cnt = cmp_p_if.hit; // R6
			end
		end else if (mode_ff == MODE_PWM) begin
			set_a = cmp_a_if.hit && !cmp_a_if.value_zero; // R16
			set_p = cmp_p_if.hit; // R16
			clear_cnt = cmp_p_if.hit; // R13 R14
		end else begin
			clear_cnt = cmp_p_if.hit;
		end
	end

	// A wrap from 3FF to zero needs no clear: the add already gives zero.
	always_comb begin
		nxt_cnt = cnt_ff;
		if (on_rise) begin
			nxt_cnt = CNT_ZERO; // R20
		end else if (step) begin
			nxt_cnt = clear_cnt ? CNT_ZERO : cnt_plus; // R15 R23
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_ff <= CNT_ZERO;
		end else begin
			cnt_ff <= nxt_cnt; // R1
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			on_ff <= 1'b0;
			pause_ff <= 1'b0;
		end else if (reg_wr && (reg_addr == ADDR_CTRL_ZERO)) begin
			on_ff <= reg_wdata[ON_BIT]; // R20
			pause_ff <= reg_wdata[PAUSE_BIT]; // R22
		end
	end

	// Mode and pin action should only be changed with the counter off.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mode_ff <= MODE_CMP;
			action_ff <= ACT_NONE;
			init_ff <= 1'b0;
			inv_ff <= 1'b0;
			cclr_ff <= 1'b0;
		end else if (reg_wr && (reg_addr == ADDR_CTRL_ONE)) begin
			mode_ff <= reg_wdata[MODE_HI:MODE_LO]; // R5
			action_ff <= reg_wdata[ACT_HI:ACT_LO]; // R21
			init_ff <= reg_wdata[INIT_BIT];
			inv_ff <= reg_wdata[INV_BIT];
			cclr_ff <= reg_wdata[CCLR_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cmpa_ff <= CNT_ZERO;
		end else if (reg_wr && (reg_addr == ADDR_CMPA_LO)) begin
			cmpa_ff[DATA_W-1:0] <= reg_wdata; // R3
		end else if (reg_wr && (reg_addr == ADDR_CMPA_HI)) begin
			cmpa_ff[CNT_W-1:DATA_W] <= reg_wdata[CNT_W-DATA_W-1:0]; // R3
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			per_ff <= CNT_ZERO;
		end else if (reg_wr && (reg_addr == ADDR_PER_LO)) begin
			per_ff[DATA_W-1:0] <= reg_wdata; // R4
		end else if (reg_wr && (reg_addr == ADDR_PER_HI)) begin
			per_ff[CNT_W-1:DATA_W] <= reg_wdata[CNT_W-DATA_W-1:0]; // R4
		end
	end

	// Writing a one clears a flag; a match in the same cycle wins.
	assign clr_a = reg_wr && (reg_addr == ADDR_FLAGS) && reg_wdata[FLAG_A_BIT];
	assign clr_p = reg_wr && (reg_addr == ADDR_FLAGS) && reg_wdata[FLAG_P_BIT];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flag_a_ff <= 1'b0;
			flag_p_ff <= 1'b0;
		end else begin
			flag_a_ff <= set_a || (flag_a_ff && !clr_a); // R24
			flag_p_ff <= set_p || (flag_p_ff && !clr_p); // R24 R7
		end
	end

	always_comb begin
		nxt_level = level_ff;
		if (on_rise) begin
			nxt_level = init_ff; // R11
		end else if ((mode_ff == MODE_CMP) && set_a) begin // R9
			unique case (action_ff) // R10 R21
				ACT_NONE: nxt_level = level_ff;
				ACT_LOW: nxt_level = 1'b0;
				ACT_HIGH: nxt_level = 1'b1;
				ACT_TOGGLE: nxt_level = !level_ff;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			level_ff <= 1'b0;
		end else begin
			level_ff <= nxt_level;
		end
	end

	assign pwm_period = (per_ff == CNT_ZERO) ? PWM_FULL_PERIOD :
		{1'b0, per_ff}; // R15
	assign pwm_on = (cnt_ff < cmpa_ff) ||
		({1'b0, cmpa_ff} >= pwm_period); // R14 R17

	always_comb begin
		unique case (action_ff) // R18
			PWM_INACTIVE: pwm_wave = 1'b0;
			PWM_ACTIVE: pwm_wave = 1'b1;
			PWM_WAVE: pwm_wave = pwm_on;
			default: pwm_wave = 1'b0;
		endcase
	end

	// The pin is registered, so it trails the counter by one clock.
	always_comb begin
		nxt_pin_out = 1'b0;
		if (mode_ff == MODE_CMP) begin
			nxt_pin_out = level_ff ^ inv_ff;
		end else if (mode_ff == MODE_PWM) begin
			nxt_pin_out = (pwm_wave ? init_ff : !init_ff) ^ inv_ff; // R19
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_out_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff <= (mode_ff == MODE_CMP) || (mode_ff == MODE_PWM); // R12
		end
	end

	always_comb begin
		nxt_rdata = BYTE_ZERO;
		unique case (reg_addr)
			ADDR_CTRL_ZERO: nxt_rdata = {pause_ff, 3'h0, on_ff, 3'h0};
			ADDR_CTRL_ONE: nxt_rdata = {mode_ff, action_ff, init_ff, inv_ff,
				1'b0, cclr_ff};
			ADDR_CNT_LO: nxt_rdata = cnt_ff[DATA_W-1:0]; // R1
			ADDR_CNT_HI: nxt_rdata = {HI_PAD, cnt_ff[CNT_W-1:DATA_W]}; // R2
			ADDR_CMPA_LO: nxt_rdata = cmpa_ff[DATA_W-1:0];
			ADDR_CMPA_HI: nxt_rdata = {HI_PAD, cmpa_ff[CNT_W-1:DATA_W]}; // R2
			ADDR_PER_LO: nxt_rdata = per_ff[DATA_W-1:0];
			ADDR_PER_HI: nxt_rdata = {HI_PAD, per_ff[CNT_W-1:DATA_W]}; // R2
			ADDR_FLAGS: nxt_rdata = {HI_PAD, flag_p_ff, flag_a_ff};
			default: nxt_rdata = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_ff <= BYTE_ZERO;
		end else begin
			rdata_ff <= reg_rd ? nxt_rdata : BYTE_ZERO;
		end
	end

	assign reg_rdata = rdata_ff;
	assign pin_out = pin_out_ff;
	assign pin_oe = pin_oe_ff;
	assign a_match_flag = flag_a_ff;
	assign p_match_flag = flag_p_ff;

	property p_cnt_step;
		@(posedge clock) disable iff (sys_rst)
		!$stable(cnt_ff) |-> (cnt_ff == $past(cnt_ff) + CNT_ONE) ||
			(cnt_ff == CNT_ZERO);
	endproperty
	a_cnt_step: assert property (p_cnt_step) // R1
		else $error("Counter moved other than by one or to zero.");
	property p_hi_pad;
		@(posedge clock) disable iff (sys_rst)
		reg_rd && ((reg_addr == ADDR_CNT_HI) || (reg_addr == ADDR_CMPA_HI) ||
			(reg_addr == ADDR_PER_HI)) |=>
			(reg_rdata[DATA_W-1:CNT_W-DATA_W] == HI_PAD);
	endproperty
	a_hi_pad: assert property (p_hi_pad) // R2
		else $error("Unused high-byte bits read as nonzero.");
	property p_cmpa_write;
		@(posedge clock) disable iff (sys_rst)
		reg_wr && (reg_addr == ADDR_CMPA_LO) |=>
			(cmpa_ff[DATA_W-1:0] == $past(reg_wdata));
	endproperty
	a_cmpa_write: assert property (p_cmpa_write) // R3
		else $error("Compare-A low byte did not take the write.");
	property p_p_clear;
		@(posedge clock) disable iff (sys_rst)
		cmp_like && !cclr_ff && step && !on_rise && (cnt_plus == per_ff) |=>
			(cnt_ff == CNT_ZERO) && flag_p_ff;
	endproperty
	a_p_clear: assert property (p_p_clear) // R6
		else $error("Period match did not clear counter and raise flag.");
	property p_no_p_flag;
		@(posedge clock) disable iff (sys_rst)
		cmp_like && cclr_ff && !flag_p_ff |=> !flag_p_ff;
	endproperty
	a_no_p_flag: assert property (p_no_p_flag) // R7
		else $error("Period flag raised with A clear selected.");
	property p_zero_a;
		@(posedge clock) disable iff (sys_rst)
		cmp_like && (cmpa_ff == CNT_ZERO) && !flag_a_ff |=> !flag_a_ff;
	endproperty
	a_zero_a: assert property (p_zero_a) // R8
		else $error("A flag raised with compare-A at zero.");
	property p_on_rise;
		@(posedge clock) disable iff (sys_rst)
		on_rise |=> (cnt_ff == CNT_ZERO) && (level_ff == $past(init_ff));
	endproperty
	a_on_rise: assert property (p_on_rise) // R11
		else $error("Counter-on rise did not reset counter and pin level.");

	property p_timer_pin;
		@(posedge clock) disable iff (sys_rst)
		(mode_ff == MODE_TMR) |=> !pin_oe && !pin_out;
	endproperty
	a_timer_pin: assert property (p_timer_pin) // R12
		else $error("Pin driven in timer mode.");

	property p_pause;
		@(posedge clock) disable iff (sys_rst)
		pause_ff && !on_rise |=> $stable(cnt_ff);
	endproperty
	a_pause: assert property (p_pause) // R22
		else $error("Counter moved while paused.");

	property p_full_duty;
		@(posedge clock) disable iff (sys_rst)
		(mode_ff == MODE_PWM) && (action_ff == PWM_WAVE) &&
			({1'b0, cmpa_ff} >= pwm_period) |=> (pin_out == ($past(init_ff) ^
			$past(inv_ff)));
	endproperty
	a_full_duty: assert property (p_full_duty) // R17
		else $error("Full duty did not hold the pin active.");

	property p_flag_hold;
		@(posedge clock) disable iff (sys_rst)
		flag_a_ff && !clr_a |=> flag_a_ff;
	endproperty
	a_flag_hold: assert property (p_flag_hold) // R24
		else $error("A flag dropped without a clear.");
endmodule : ptc_timer
`default_nettype wire

// ===== tb/ptc_pin_load.sv
// Model of the circuit hanging on the timer output pin.
`timescale 1ns/100ps
`default_nettype none
module ptc_pin_load (
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_line
);
	// A pull-down holds the line low whenever the timer lets go of it.
	assign pin_line = pin_oe ? pin_out : 1'b0;
endmodule : ptc_pin_load
`default_nettype wire

// ===== tb/ptc_timer_test.sv
// Self-checking bench for the periodic timer.
`timescale 1ns/100ps
`default_nettype none
module ptc_timer_test;
	import ptc_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic count_tick = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic pin_out, pin_oe, a_match_flag, p_match_flag, pin_line;
	logic rd_seen = 1'b0;
	logic ep;
	logic [7:0] expq[$];
	logic [31:0] seed = 32'h00013cd7;
	logic [7:0] pc[6] = '{8'had, 8'ha9, 8'h89, 8'h99, 8'ha1, 8'hb9};
	logic [7:0] pa[6] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
	logic pe[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
	int err_total = 0;
	int tests_run = 0;
	int i;

	always #25 clock = ~clock;

	ptc_timer ptc_timer_i (.clock(clock), .sys_rst(sys_rst),
		.count_tick(count_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pin_out(pin_out), .pin_oe(pin_oe), .a_match_flag(a_match_flag),
		.p_match_flag(p_match_flag));
	ptc_pin_load ptc_pin_load_i (.pin_out(pin_out), .pin_oe(pin_oe),
		.pin_line(pin_line));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	task chk(input string n, input logic [9:0] e, input logic [9:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task results;
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results

	// Strobes are dropped one edge later, so two calls never touch a signal
	// twice in the same time step.
	task bus(input logic w, input logic r, input logic [3:0] a,
		input logic [7:0] d);
		@(posedge clock);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : bus

	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wr

	task rd(input logic [3:0] a, input logic [7:0] e);
		expq.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd

	task tk(input int n);
		repeat (n) begin
			@(posedge clock);
			count_tick <= 1'b1;
			@(posedge clock);
			count_tick <= 1'b0;
		end
	endtask : tk

	task settle;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask : settle

	task setup(input logic [7:0] c1);
		wr(ADDR_CTRL_ZERO, 8'h00);
		wr(ADDR_CTRL_ONE, c1);
		wr(ADDR_CTRL_ZERO, 8'h08);
	endtask : setup

	always @(posedge clock) rd_seen <= reg_rd;

	always @(negedge clock) begin
		if (rd_seen) begin
			chk("rdata", {2'b00, expq.pop_front()}, {2'b00, reg_rdata});
		end
	end

	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		results();
	end

	initial begin
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		for (i = 0; i < 16; i++) begin
			rd(i[3:0], 8'h00);
		end
		seed = xs(seed);
		wr(ADDR_CMPA_LO, seed[7:0]);
		wr(ADDR_CMPA_HI, seed[15:8]);
		wr(ADDR_PER_LO, seed[23:16]);
		wr(ADDR_PER_HI, seed[31:24]);
		wr(ADDR_CNT_LO, seed[7:0]);
		wr(ADDR_CNT_HI, 8'hff);
		rd(ADDR_CMPA_LO, seed[7:0]);
		rd(ADDR_CMPA_HI, {HI_PAD, seed[9:8]});
		rd(ADDR_PER_LO, seed[23:16]);
		rd(ADDR_PER_HI, {HI_PAD, seed[25:24]});
		rd(ADDR_CNT_LO, 8'h00);
		rd(ADDR_CNT_HI, 8'h00);
		wr(ADDR_CMPA_LO, 8'h03);
		wr(ADDR_CMPA_HI, 8'h00);
		wr(ADDR_PER_LO, 8'h05);
		wr(ADDR_PER_HI, 8'h00);
		for (i = 0; i < 4; i++) begin
			ep = (i != 1);
			setup({2'b00, i[1:0], (i != 2), (i == 3), 2'b00});
			settle;
			chk("pin", {9'h000, (i != 2) ^ (i == 3)}, {9'h000, pin_line});
			tk(3);
			settle;
			chk("pin", {9'h000, ep}, {9'h000, pin_line});
			chk("flags", 10'h001, {8'h00, p_match_flag, a_match_flag});
			tk(2);
			settle;
			chk("pin", {9'h000, ep}, {9'h000, pin_line});
			chk("flags", 10'h003, {8'h00, p_match_flag, a_match_flag});
			rd(ADDR_CNT_LO, 8'h00);
			wr(ADDR_FLAGS, 8'h03);
			settle;
			chk("flags", 10'h000, {8'h00, p_match_flag, a_match_flag});
		end
		tk(1);
		wr(ADDR_CTRL_ZERO, 8'h88);
		tk(2);
		rd(ADDR_CNT_LO, 8'h01);
		wr(ADDR_CTRL_ZERO, 8'h08);
		tk(1);
		rd(ADDR_CNT_LO, 8'h02);
		wr(ADDR_CTRL_ZERO, 8'h00);
		tk(2);
		rd(ADDR_CNT_LO, 8'h02);
		wr(ADDR_CTRL_ZERO, 8'h08);
		rd(ADDR_CNT_LO, 8'h00);
		settle;
		chk("pin", 10'h000, {9'h000, pin_line});
		wr(ADDR_PER_LO, 8'h02);
		setup(8'hf9);
		tk(3);
		rd(ADDR_CNT_LO, 8'h00);
		rd(ADDR_FLAGS, 8'h01);
		settle;
		chk("oe", 10'h000, {8'h00, pin_oe, pin_line});
		wr(ADDR_FLAGS, 8'h03);
		wr(ADDR_CMPA_LO, 8'h00);
		setup(8'h01);
		tk(1023);
		rd(ADDR_CNT_LO, 8'hff);
		rd(ADDR_CNT_HI, 8'h03);
		tk(1);
		rd(ADDR_CNT_LO, 8'h00);
		rd(ADDR_FLAGS, 8'h00);
		wr(ADDR_PER_LO, 8'h04);
		wr(ADDR_CMPA_LO, 8'h01);
		setup(8'ha9);
		settle;
		chk("pin", 10'h001, {9'h000, pin_line});
		tk(1);
		settle;
		chk("pin", 10'h000, {9'h000, pin_line});
		tk(1);
		rd(ADDR_CNT_LO, 8'h02);
		tk(2);
		rd(ADDR_CNT_LO, 8'h00);
		rd(ADDR_FLAGS, 8'h03);
		settle;
		chk("pin", 10'h001, {9'h000, pin_line});
		for (i = 0; i < 6; i++) begin
			wr(ADDR_CMPA_LO, pa[i]);
			setup(pc[i]);
			tk(2);
			rd(ADDR_CNT_LO, 8'h02);
			settle;
			chk("pin", {9'h000, pe[i]}, {9'h000, pin_line});
		end
		wr(ADDR_FLAGS, 8'h03);
		wr(ADDR_PER_LO, 8'h00);
		setup(8'h40);
		tk(5);
		rd(ADDR_FLAGS, 8'h00);
		settle;
		chk("oe", 10'h000, {8'h00, pin_oe, pin_line});
		setup(8'ha9);
		tk(1023);
		rd(ADDR_CNT_HI, 8'h03);
		settle;
		chk("pin", 10'h000, {9'h000, pin_line});
		tk(1);
		rd(ADDR_CNT_LO, 8'h00);
		rd(ADDR_FLAGS, 8'h03);
		settle;
		chk("pin", 10'h001, {9'h000, pin_line});
		repeat (3) @(posedge clock);
		results();
	end
endmodule : ptc_timer_test
`default_nettype wire
